// >>> core/fsmr_core.sv
// Purpose: Program-store control, flash read timing and external-move routing
// Assumes: Core presents one SFR access or one move per cycle, synchronous to clk
// Notes:   Routed outputs are registered and valid one cycle after the request
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: Read one-shot enable bit, 0 off, 1 on
// RL2: One-shot off: sense amps on a full cycle
// RL3: Software picks smallest read-time select for clock
// RL4: Move writes may be redirected to flash
// RL5: No redirection: moves go to data RAM
// RL6: Short-address moves take upper byte from page
// RL7: On-chip RAM mapped into external data space
// RL8: FIFO RAM optionally mapped into data space
// RL9: FIFO enable maps 0x0400-0x07FF to FIFO
// RL10: Forbidden flash page access raises error reset
// RL11: Write enable programs; with erase, erases page
module fsmr_core #(
  parameter int RAM_KB      = 4,
  parameter int PAGE_BITS   = 9,
  parameter int FLASH_KB    = 64
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // SFR port
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  output logic      [7:0]          sfr_rdata,
  output logic                     sfr_hit,
  // External-move request from the core
  input  fsmr_pkg::fsmr_move_s     move,
  input  wire logic [7:0]          reg_low,
  // Flash access policy from the lock logic
  input  wire logic                page_forbidden,
  // Flash read strobe from the fetch path
  input  wire logic                flash_rd,
  // Routed access and status
  output fsmr_pkg::fsmr_route_s    route,
  output logic                     route_valid,
  output logic                     sense_en,
  output logic                     read_time_sel,
  output logic                     flash_err_rst
);
  import fsmr_pkg::*;

  // Parameter checks at elaboration; FLASH_KB and PAGE_BITS only bound the variants
  if (RAM_KB != 4 && RAM_KB != 2) begin : g_ram_chk
    $error("RAM_KB must be 2 or 4");
  end
  if (PAGE_BITS < 1 || PAGE_BITS > 15) begin : g_page_chk
    $error("PAGE_BITS out of range");
  end
  if (FLASH_KB != 64 && FLASH_KB != 32) begin : g_flash_chk
    $error("FLASH_KB must be 32 or 64");
  end

  // Top of on-chip RAM for this variant
  localparam logic [15:0] RAM_TOP = (RAM_KB == 4) ? FSMR_RAM4K_TOP : FSMR_RAM2K_TOP;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] psc_r, psc_nxt;
  logic [7:0] frt_r, frt_nxt;
  logic [7:0] page_r, page_nxt;
  logic [7:0] cfg_r, cfg_nxt;

  // Next values of the SFRs
  always_comb begin
    psc_nxt  = psc_r;
    frt_nxt  = frt_r;
    page_nxt = page_r;
    cfg_nxt  = cfg_r;
    // Unknown addresses leave every register as it was
    if (sfr_wr) begin
      if (sfr_addr == FSMR_PSC_ADDR) begin
        psc_nxt = sfr_wdata & FSMR_PSC_MASK;
      end else if (sfr_addr == FSMR_FRT_ADDR) begin
        frt_nxt = sfr_wdata & FSMR_FRT_MASK; // RL1
      end else if (sfr_addr == FSMR_PAGE_ADDR) begin
        page_nxt = sfr_wdata;
      end else if (sfr_addr == FSMR_CFG_ADDR) begin
        cfg_nxt = sfr_wdata & FSMR_CFG_MASK;
      end
    end
  end

  // SFR storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psc_r  <= FSMR_PSC_RST;
      frt_r  <= FSMR_FRT_RST;
      page_r <= FSMR_PAGE_RST;
      cfg_r  <= FSMR_CFG_RST;
    end else begin
      psc_r  <= psc_nxt;
      frt_r  <= frt_nxt;
      page_r <= page_nxt;
      cfg_r  <= cfg_nxt;
    end
  end

  // Read decode, unmapped reads return zero with no hit
  always_comb begin
    sfr_rdata = 8'h00;
    sfr_hit   = 1'b0;
    if (sfr_rd) begin
      if (sfr_addr == FSMR_PSC_ADDR) begin
        sfr_rdata = psc_r;
        sfr_hit   = 1'b1;
      end else if (sfr_addr == FSMR_FRT_ADDR) begin
        sfr_rdata = frt_r;
        sfr_hit   = 1'b1;
      end else if (sfr_addr == FSMR_PAGE_ADDR) begin
        sfr_rdata = page_r;
        sfr_hit   = 1'b1;
      end else if (sfr_addr == FSMR_CFG_ADDR) begin
        sfr_rdata = cfg_r;
        sfr_hit   = 1'b1;
      end
    end
  end

  // Control bits picked out of the registers
  logic store_write_enable;
  logic store_erase_enable;
  logic read_one_shot_enable;
  logic fifo_access_enable;
  assign store_write_enable   = psc_r[FSMR_WREN_BIT];
  assign store_erase_enable   = psc_r[FSMR_ERASE_BIT];
  assign read_one_shot_enable = frt_r[FSMR_ONESHOT_BIT];
  assign fifo_access_enable   = cfg_r[FSMR_FAE_BIT];
  assign read_time_sel        = frt_r[FSMR_RTIME_BIT]; // RL3

  ////////////////////////////////////////////////////////////////////////////
  // Flash sense-amp timing
  // Strobe of the previous cycle
  logic sense_r, sense_nxt;

  // Every read is remembered, so a switch-off of the one-shot still stretches it
  always_comb begin
    sense_nxt = 1'b0;
    if (flash_rd) begin
      sense_nxt = (FSMR_SENSE_CYC != 0); // RL2
    end
  end

  // Sense history register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sense_r <= 1'b0;
    end else begin
      sense_r <= sense_nxt;
    end
  end

  // One-shot on follows the strobe; off holds the amps a full extra cycle
  assign sense_en = read_one_shot_enable ? flash_rd : (sense_r | flash_rd); // RL1 RL2

  ////////////////////////////////////////////////////////////////////////////
  // External-move routing
  // Registered route, its strobe and the error pulse
  fsmr_route_s route_r, route_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic        err_r, err_nxt;
  logic [15:0] eff_addr;

  // Effective address, page byte over the low register byte
  assign eff_addr = move.short_addr ? {page_r, reg_low} : move.addr; // RL6

  // Pick the destination of each move
  always_comb begin
    route_nxt       = route_r;
    rvalid_nxt      = 1'b0;
    err_nxt         = 1'b0;
    if (move.valid) begin
      rvalid_nxt      = 1'b1;
      route_nxt.addr  = eff_addr;
      route_nxt.wdata = move.wdata;
      route_nxt.write = move.write;
      // Flash operations outrank every data-space window
      if (move.write && store_write_enable) begin
        if (page_forbidden) begin
          route_nxt.dst = FSMR_DST_NONE;
          err_nxt       = 1'b1; // RL10
        end else if (store_erase_enable) begin
          route_nxt.dst = FSMR_DST_FLASH_ER; // RL11
        end else begin
          route_nxt.dst = FSMR_DST_FLASH_WR; // RL4 RL11
        end
      end else if (fifo_access_enable && eff_addr >= FSMR_FIFO_LO && eff_addr <= FSMR_FIFO_HI) begin
        route_nxt.dst = FSMR_DST_FIFO; // RL8 RL9
      end else if (eff_addr <= RAM_TOP) begin
        route_nxt.dst = FSMR_DST_RAM; // RL5 RL7
      end else begin
        route_nxt.dst = FSMR_DST_EXT; // RL5
      end
    end
  end

  // Route registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      route_r  <= '0;
      rvalid_r <= 1'b0;
      err_r    <= 1'b0;
    end else begin
      route_r  <= route_nxt;
      rvalid_r <= rvalid_nxt;
      err_r    <= err_nxt;
    end
  end

  // Registered outputs
  assign route         = route_r;
  assign route_valid   = rvalid_r;
  assign flash_err_rst = err_r;

endmodule : fsmr_core

// >>> core/fsmr_pkg.sv
// Purpose: Shared constants and types for the program-store control and external-move router
// Assumes: Special-function registers are reached over the core's SFR port at byte addresses
// Notes:   One clock domain; all counts are in system clock cycles
package fsmr_pkg;

  // Special-function register addresses
  localparam logic [7:0] FSMR_PSC_ADDR   = 8'h8f;
  localparam logic [7:0] FSMR_FRT_ADDR   = 8'hb6;
  localparam logic [7:0] FSMR_PAGE_ADDR  = 8'haa;
  localparam logic [7:0] FSMR_CFG_ADDR   = 8'h85;

  // Reset values
  localparam logic [7:0] FSMR_PSC_RST    = 8'h00;
  localparam logic [7:0] FSMR_FRT_RST    = 8'h80;
  localparam logic [7:0] FSMR_PAGE_RST   = 8'h00;
  localparam logic [7:0] FSMR_CFG_RST    = 8'h00;

  // Field positions
  localparam int FSMR_WREN_BIT    = 0;
  localparam int FSMR_ERASE_BIT   = 1;
  localparam int FSMR_RTIME_BIT   = 4;
  localparam int FSMR_ONESHOT_BIT = 7;
  localparam int FSMR_FAE_BIT   = 6;

  // Writable masks; reserved bits read zero
  localparam logic [7:0] FSMR_PSC_MASK   = 8'h03;
  localparam logic [7:0] FSMR_FRT_MASK   = 8'h90;
  localparam logic [7:0] FSMR_CFG_MASK   = 8'h40;

  // Data-space windows
  localparam logic [15:0] FSMR_FIFO_LO   = 16'h0400;
  localparam logic [15:0] FSMR_FIFO_HI   = 16'h07ff;
  localparam logic [15:0] FSMR_RAM4K_TOP = 16'h0fff;
  localparam logic [15:0] FSMR_RAM2K_TOP = 16'h07ff;

  // Flash sense time in clock cycles when the one-shot is off
  localparam int FSMR_SENSE_CYC = 1;

  // Destination of an external-move access
  typedef enum logic [2:0] {
    FSMR_DST_RAM,
    FSMR_DST_FIFO,
    FSMR_DST_EXT,
    FSMR_DST_FLASH_WR,
    FSMR_DST_FLASH_ER,
    FSMR_DST_NONE
  } fsmr_dst_e;

  // External-move request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        short_addr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fsmr_move_s;

  // Routed access toward memories
  typedef struct packed {
    logic [2:0]  dst;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        write;
  } fsmr_route_s;

endpackage : fsmr_pkg

// >>> tb/fsmr_checker.sv
// Purpose: Port assertions for the store control and move router
// Assumes: One clock, rstn active low
// Notes:   One-shot state mirrored from SFR writes
`timescale 1ns/1ns
module fsmr_checker (
  // Clock and reset
  input wire logic            clk,
  input wire logic            rstn,
  // Watched ports
  input wire logic            sfr_wr,
  input wire logic [7:0]      sfr_addr,
  input wire logic [7:0]      sfr_wdata,
  input fsmr_pkg::fsmr_move_s move,
  input wire logic [7:0]      reg_low,
  input wire logic            flash_rd,
  input fsmr_pkg::fsmr_route_s route,
  input logic                 route_valid,
  input logic                 sense_en,
  input logic                 read_time_sel,
  input logic                 flash_err_rst
);
  import fsmr_pkg::*;
  logic os_r;
  logic os_nxt;
  // Mirror of the one-shot enable
  always_comb os_nxt = (sfr_wr && sfr_addr == 8'hb6) ? sfr_wdata[7] : os_r;
  always_ff @(posedge clk or negedge rstn) if (!rstn) os_r <= 1'b1; else os_r <= os_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ans; move.valid |=> route_valid; endproperty
  a_ans: assert property (p_ans) else $error("no route after move");
  property p_ext;
    move.valid && !move.write && !move.short_addr && move.addr[15:12] != 4'h0 |=> route.dst == 3'd2;
  endproperty
  a_ext: assert property (p_ext) else $error("high read not external");
  property p_page; move.valid && move.short_addr |=> route.addr[7:0] == $past(reg_low); endproperty
  a_page: assert property (p_page) else $error("short move low byte");
  property p_err; flash_err_rst |-> route_valid && route.dst == 3'd5; endproperty
  a_err: assert property (p_err) else $error("error reset without refusal");
  property p_fw; route_valid && route.dst inside {3'd3, 3'd4} |-> $past(move.write); endproperty
  a_fw: assert property (p_fw) else $error("flash op from read");
  property p_rd; move.valid && !move.write |=> !flash_err_rst && route.dst < 3'd3; endproperty
  a_rd: assert property (p_rd) else $error("read became flash op");
  property p_os; os_r && !flash_rd |-> !sense_en; endproperty
  a_os: assert property (p_os) else $error("sense on in one-shot idle");
  property p_full; !os_r && $past(flash_rd) |-> sense_en; endproperty
  a_full: assert property (p_full) else $error("sense cut short");
  property p_rts; sfr_wr && sfr_addr == 8'hb6 && sfr_wdata[4] |=> read_time_sel; endproperty
  a_rts: assert property (p_rts) else $error("read time not set");
endmodule : fsmr_checker
bind fsmr_core fsmr_checker u_chk (.clk(clk), .rstn(rstn), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .move(move), .reg_low(reg_low), .flash_rd(flash_rd), .route(route),
  .route_valid(route_valid), .sense_en(sense_en), .read_time_sel(read_time_sel), .flash_err_rst(flash_err_rst));

// >>> tb/fsmr_cpu_model.sv
// Purpose: Core side issuing SFR cycles and external moves
// Assumes: Requests change just after the rising edge
// Notes:   One request per call, back to back allowed
`timescale 1ns/1ns
module fsmr_cpu_model (
  input wire logic            clk,
  input wire logic [7:0]      sfr_rdata,
  output logic                sfr_wr,
  output logic                sfr_rd,
  output logic [7:0]          sfr_addr,
  output logic [7:0]          sfr_wdata,
  output fsmr_pkg::fsmr_move_s move,
  output logic [7:0]          reg_low,
  output logic                page_forbidden
);
  import fsmr_pkg::*;
  // Idle at time zero
  initial {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, move, reg_low, page_forbidden} = '0;
  // One SFR cycle, read data taken mid-cycle
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {w, !w, a, d};
    move.valid <= 1'b0;
    @(negedge clk);
    q = sfr_rdata;
  endtask : sfr
  // One move request
  task automatic mv(input logic w, s, input logic [15:0] a, input logic [7:0] lo, input logic f);
    @(posedge clk);
    move <= '{1'b1, w, s, a, ~lo};
    {reg_low, page_forbidden, sfr_wr, sfr_rd} <= {lo, f, 2'b00};
  endtask : mv
  // Release all strobes
  task automatic idle();
    @(posedge clk);
    {move.valid, sfr_wr, sfr_rd} <= 3'b000;
  endtask : idle
endmodule : fsmr_cpu_model

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the store control and move router
// Assumes: 125 MHz clock, reset held three cycles
// Notes:   Driver queues expected routes, a monitor compares them
`timescale 1ns/1ns
module tb_top;
  import fsmr_pkg::*;
  logic clk, rstn, flash_rd, sfr_wr, sfr_rd, route_valid, sense_en, rts, err, hit, forb;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, reg_low, q;
  logic [15:0] a, rs = 16'd31447;
  logic [28:0] e;
  logic [28:0] eq[$];
  fsmr_move_s move;
  fsmr_route_s route;
  int fails, compares;
  fsmr_core uut (.clk(clk), .rstn(rstn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(hit), .move(move), .reg_low(reg_low),
    .page_forbidden(forb), .flash_rd(flash_rd), .route(route), .route_valid(route_valid),
    .sense_en(sense_en), .read_time_sel(rts), .flash_err_rst(err));
  fsmr_cpu_model u_cpu (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .move(move), .reg_low(reg_low), .page_forbidden(forb));
  // Xorshift source
  function automatic logic [15:0] rnd();
    rs ^= rs << 7;
    rs ^= rs >> 9;
    rs ^= rs << 8;
    return rs;
  endfunction : rnd
  task automatic chk(input string n, input logic [28:0] x, input logic [28:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask : chk
  task automatic rd(input logic [7:0] ad, input logic [7:0] x);
    u_cpu.sfr(1'b0, ad, 8'h00, q);
    chk("sfr", {21'h0, x}, {21'h0, q});
    chk("hit", {28'h0, ad inside {FSMR_PSC_ADDR, FSMR_FRT_ADDR, FSMR_PAGE_ADDR, FSMR_CFG_ADDR}}, {28'h0, hit});
  endtask : rd
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    u_cpu.sfr(1'b1, ad, d, q);
  endtask : wr
  task automatic mv(input logic w, s, input logic [15:0] ad, input logic [7:0] lo, input logic f,
                    input logic [2:0] dst, input logic [15:0] ea);
    eq.push_back({dst, ea, ~lo, w, dst == 3'd5});
    u_cpu.mv(w, s, ad, lo, f);
  endtask : mv
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // Clock and random sense strobe
  initial begin
    clk = 0;
    flash_rd = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) flash_rd <= ^rnd();
  // Route monitor
  always @(negedge clk) if (rstn && route_valid === 1'b1) begin
    e = (eq.size() == 0) ? '1 : eq.pop_front();
    chk("route", e, {route.dst, route.addr, route.wdata, route.write, err});
  end
  // Main sequence
  initial begin
    rstn = 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    rd(8'h8f, 8'h00);
    chk("rts", 29'h0, {28'h0, rts});
    rd(8'hb6, 8'h80);
    rd(8'h85, 8'h00);
    rd(8'h90, 8'h00);
    wr(8'hb6, 8'hff);
    rd(8'hb6, 8'h90);
    wr(8'hb6, 8'h10);
    wr(8'h85, 8'h40);
    chk("rts", 29'h1, {28'h0, rts});
    wr(8'haa, 8'h12);
    mv(0, 0, 16'h0500, 0, 0, 3'd1, 16'h0500);
    mv(0, 0, 16'h0200, 0, 0, 3'd0, 16'h0200);
    mv(0, 1, 16'h0000, 8'h34, 0, 3'd2, 16'h1234);
    for (int i = 0; i < 24; i++) begin
      a = rnd() | 16'h1000;
      mv(a[0], 0, a, a[15:8], a[1], 3'd2, a);
    end
    wr(8'h85, 8'h00);
    mv(0, 0, 16'h0500, 0, 0, 3'd0, 16'h0500);
    wr(8'h8f, 8'h01);
    mv(1, 0, 16'h0300, 0, 0, 3'd3, 16'h0300);
    mv(0, 0, 16'h3000, 0, 1, 3'd2, 16'h3000);
    wr(8'h8f, 8'h03);
    mv(1, 0, 16'h0600, 0, 0, 3'd4, 16'h0600);
    mv(1, 0, 16'h0600, 0, 1, 3'd5, 16'h0600);
    wr(8'hb6, 8'h80);
    u_cpu.idle();
    for (int i = 0; i < 10 && eq.size() > 0; i++) @(posedge clk);
    if (eq.size() > 0) fails++;
    @(negedge clk);
    chk("rts", 29'h0, {28'h0, rts});
    finish_test();
  end
  // Hang limit
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    finish_test();
  end
endmodule : tb_top
